// ---- common/sfl_pkg.sv ----
/*
  Shared constants and types for the serial flash command block: opcodes,
  status byte layout, protection boundaries, identifier values, timing.
  Assumes a 100 MHz system clock; the serial clock comes from the host.
*/
`default_nettype none
package sfl_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_SECTOR_CLEAR = 8'hD8;
  localparam logic [7:0] OP_FULL_CLEAR = 8'hC7;
  localparam logic [7:0] OP_WAKE_AND_ID = 8'hAB;
  localparam logic [7:0] OP_MAKER_PART_ID = 8'h90;

  // ************************************************************
  // frame byte counts (complete bytes seen while selected)
  // ************************************************************
  localparam logic [3:0] NB_ONE = 4'h1;
  localparam logic [3:0] NB_STATUS_WRITE = 4'h2;
  localparam logic [3:0] NB_ADDR_LAST = 4'h3;
  localparam logic [3:0] NB_FAST_DUMMY = 4'h4;
  localparam logic [3:0] NB_SECTOR = 4'h4;
  localparam logic [3:0] NB_PAGE_MIN = 4'h5;
  localparam logic [3:0] NB_SAT = 4'hF;
  localparam logic [3:0] NB_FIRST_DATA = 4'h1;

  // ************************************************************
  // address space and protection boundaries
  // ************************************************************
  localparam logic [23:0] ADDR_TOP = 24'h07_FFFF;
  localparam logic [23:0] ADDR_ZERO = 24'h00_0000;
  localparam logic [23:0] PROT_HALF_BASE = 24'h04_0000;
  localparam logic [23:0] PROT_QUARTER_BASE = 24'h06_0000;
  localparam logic [23:0] PROT_EIGHTH_BASE = 24'h07_0000;
  localparam logic [2:0] PROT_NONE = 3'h0;
  localparam logic [2:0] PROT_EIGHTH = 3'h1;
  localparam logic [2:0] PROT_QUARTER = 3'h2;
  localparam logic [2:0] PROT_HALF = 3'h3;

  // ************************************************************
  // identifiers (values arbitrary)
  // ************************************************************
  localparam logic [7:0] MAKER_CODE = 8'hA5;
  localparam logic [7:0] PART_CODE = 8'h5A;

  // ************************************************************
  // status byte: bit7 lock, 6:5 reserved, 4:2 protect size, 1 latch, 0 busy
  // ************************************************************
  typedef struct packed {
    logic status_lock_bit;
    logic [1:0] reserved;
    logic protect_size_hi;
    logic protect_size_mid;
    logic protect_size_lo;
    logic write_enable_latch;
    logic cycle_running_flag;
  } sfl_status_t;

  localparam logic [2:0] PROTECT_RESET = 3'h0;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;

  // ************************************************************
  // state machines
  // ************************************************************
  typedef enum logic [8:0] {
    LK_OPC = 9'b0_0000_0001,
    LK_ADDR = 9'b0_0000_0010,
    LK_DUMMY = 9'b0_0000_0100,
    LK_RDATA = 9'b0_0000_1000,
    LK_STAT = 9'b0_0001_0000,
    LK_ID = 9'b0_0010_0000,
    LK_MID = 9'b0_0100_0000,
    LK_WIN = 9'b0_1000_0000,
    LK_IGN = 9'b1_0000_0000
  } sfl_link_st_t;

  typedef enum logic [1:0] {
    SY_IDLE = 2'b01,
    SY_CYC = 2'b10
  } sfl_sys_st_t;

  typedef enum logic [3:0] {
    KD_STATUS = 4'b0001,
    KD_PAGE = 4'b0010,
    KD_SECTOR = 4'b0100,
    KD_FULL = 4'b1000
  } sfl_kind_t;

endpackage
`default_nettype wire

// ---- hdl/sfl_flash_cmd.sv ----
/*
  Device-side command logic of a serial NOR flash: latch commands, status
  byte, array reads with auto-increment, identifier reads.
  Assumes the host stops the serial clock before raising chip select, and an
  array outside that returns mem_data_i combinationally for mem_addr_o.
*/
`default_nettype none
module sfl_flash_cmd #(
  parameter int unsigned STATUS_TIME_NS = 10_000_000,
  parameter int unsigned PAGE_TIME_NS = 1_500_000,
  parameter int unsigned SECTOR_TIME_NS = 800_000_000,
  parameter int unsigned FULL_TIME_NS = 2_000_000_000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_i,
  input wire logic wp_n_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic [23:0] mem_addr_o,
  input wire logic [7:0] mem_data_i,
  output sfl_pkg::sfl_status_t status_o,
  output logic hardware_locked_mode_o
);
  import sfl_pkg::*;

  localparam int unsigned STATUS_CYC = (STATUS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAGE_CYC = (PAGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SECTOR_CYC = (SECTOR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FULL_CYC = (FULL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // link domain (serial clock, frame bounded by chip select)
  // ************************************************************
  // power-on values: the link clock may never run while rst_i is active
  logic fresh_ff = 1'b1;
  logic frame_tgl_ff = 1'b0;
  logic [7:0] st_meta_ff = 8'h00;
  logic [7:0] st_sync_ff = 8'h00;
  sfl_link_st_t state_ff = LK_IGN;
  logic [2:0] bit_cnt_ff = 3'h0;
  logic [3:0] byte_cnt_ff = 4'h0;
  logic [7:0] shift_ff = 8'h00;
  logic [7:0] opcode_ff = 8'h00;
  logic [23:0] addr_ff = 24'h00_0000;
  logic [7:0] wdata_ff = 8'h00;
  logic [7:0] snap_ff = 8'h00;
  logic alt_ff = 1'b0;
  logic sdo_ff;
  logic oe_ff;

  sfl_link_st_t st;
  sfl_link_st_t nxt_state;
  logic [2:0] bc;
  logic [3:0] byc;
  logic [7:0] new_byte;
  logic byte_done;
  logic [2:0] nxt_bit_cnt;
  logic [3:0] nxt_byte_cnt;
  logic [7:0] nxt_opcode;
  logic [23:0] nxt_addr;
  logic [7:0] nxt_wdata;
  logic [7:0] nxt_snap;
  logic nxt_alt;
  logic nxt_tgl;
  logic [7:0] tx_byte;
  logic nxt_sdo;
  logic nxt_oe;
  logic busy_link;

  // the first edge after select always starts a new opcode
  assign st = fresh_ff ? LK_OPC : state_ff;
  assign bc = fresh_ff ? 3'h0 : bit_cnt_ff;
  assign byc = fresh_ff ? 4'h0 : byte_cnt_ff;
  assign new_byte = {shift_ff[6:0], serial_in_i};
  assign byte_done = (bc == 3'h7);
  assign busy_link = st_sync_ff[0];

  always_comb begin
    nxt_state = st;
    nxt_bit_cnt = bc + 3'h1;
    nxt_byte_cnt = byc;
    nxt_opcode = opcode_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_snap = snap_ff;
    nxt_alt = alt_ff;
    nxt_tgl = fresh_ff ? ~frame_tgl_ff : frame_tgl_ff;
    if (byte_done) begin
      nxt_byte_cnt = (byc == NB_SAT) ? NB_SAT : byc + 4'h1;
      nxt_snap = st_sync_ff;
      unique case (st)
        LK_OPC: begin
          nxt_opcode = new_byte;
          if (new_byte == OP_READ || new_byte == OP_FAST_READ) begin
            nxt_state = busy_link ? LK_IGN : LK_ADDR;
          end else if (new_byte == OP_STATUS_READ) begin
            nxt_state = LK_STAT;
          end else if (new_byte == OP_WAKE_AND_ID || new_byte == OP_MAKER_PART_ID) begin
            nxt_state = LK_DUMMY;
          end else if (new_byte == OP_PAGE_WRITE || new_byte == OP_SECTOR_CLEAR) begin
            nxt_state = LK_ADDR;
          end else begin
            nxt_state = LK_WIN;
          end
        end
        LK_ADDR: begin
          nxt_addr = {addr_ff[15:0], new_byte};
          if (byc == NB_ADDR_LAST) begin
            if (opcode_ff == OP_READ) begin
              nxt_state = LK_RDATA;
            end else if (opcode_ff == OP_FAST_READ) begin
              nxt_state = LK_DUMMY;
            end else begin
              nxt_state = LK_WIN;
            end
          end
        end
        LK_DUMMY: begin
          if (opcode_ff == OP_FAST_READ && byc == NB_FAST_DUMMY) begin
            nxt_state = LK_RDATA;
          end else if (opcode_ff == OP_WAKE_AND_ID && byc == NB_ADDR_LAST) begin
            nxt_state = LK_ID;
          end else if (opcode_ff == OP_MAKER_PART_ID && byc == NB_ADDR_LAST) begin
            nxt_state = LK_MID;
            nxt_alt = new_byte[0];
          end
        end
        LK_RDATA: begin
          nxt_addr = (addr_ff == ADDR_TOP) ? ADDR_ZERO : addr_ff + 24'h00_0001;
        end
        LK_MID: begin
          nxt_alt = ~alt_ff;
        end
        LK_WIN: begin
          if (byc == NB_FIRST_DATA) begin
            nxt_wdata = new_byte;
          end
        end
        LK_STAT, LK_ID, LK_IGN: begin
          nxt_state = st;
        end
      endcase
    end
  end

  always_ff @(posedge sclk_i) begin
    state_ff <= nxt_state;
    bit_cnt_ff <= nxt_bit_cnt;
    byte_cnt_ff <= nxt_byte_cnt;
    shift_ff <= new_byte;
    opcode_ff <= nxt_opcode;
    addr_ff <= nxt_addr;
    wdata_ff <= nxt_wdata;
    snap_ff <= nxt_snap;
    alt_ff <= nxt_alt;
    frame_tgl_ff <= nxt_tgl;
  end

  // status bits change rarely, several together only at a cycle end; each bit has its own double flop
  always_ff @(posedge sclk_i) begin
    st_meta_ff <= status_o;
    st_sync_ff <= st_meta_ff;
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  always_comb begin
    unique case (state_ff)
      LK_STAT: tx_byte = snap_ff;
      LK_ID: tx_byte = PART_CODE;
      LK_MID: tx_byte = alt_ff ? PART_CODE : MAKER_CODE;
      LK_RDATA: tx_byte = mem_data_i;
      LK_OPC, LK_ADDR, LK_DUMMY, LK_WIN, LK_IGN: tx_byte = 8'h00;
    endcase
    nxt_sdo = tx_byte[~bit_cnt_ff];
    nxt_oe = (state_ff == LK_STAT) || (state_ff == LK_ID) ||
             (state_ff == LK_MID) || (state_ff == LK_RDATA);
  end

  // output launched on the falling edge; deselect clears it without a clock
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
    end
  end

  assign sdo_o = sdo_ff;
  assign sdo_oe_o = oe_ff & ~cs_n_i;
  assign mem_addr_o = addr_ff;

  // ************************************************************
  // system domain: status byte and timed cycles
  // ************************************************************
  logic [1:0] cs_sync_ff;
  logic cs_prev_ff;
  logic [1:0] wp_sync_ff;
  logic [1:0] tgl_sync_ff;
  logic tgl_seen_ff;
  sfl_sys_st_t sy_ff;
  sfl_kind_t kind_ff;
  logic [31:0] cnt_ff;
  logic wel_ff;
  logic [2:0] prot_ff;
  logic lock_ff;
  logic [7:0] pend_ff;

  sfl_sys_st_t nxt_sy;
  sfl_kind_t nxt_kind;
  logic [31:0] nxt_cnt;
  logic nxt_wel;
  logic [2:0] nxt_prot;
  logic nxt_lock;
  logic [7:0] nxt_pend;
  logic take;
  logic aligned;
  logic busy;
  logic hw_locked;
  logic in_prot;
  logic do_write_enable_cmd;
  logic do_write_disable_cmd;
  logic do_wsr;
  logic do_page;
  logic do_sect;
  logic do_full;

  assign busy = (sy_ff == SY_CYC);
  assign hw_locked = lock_ff & ~wp_sync_ff[1];
  // link registers are quiet here: the serial clock stopped before deselect
  assign take = cs_sync_ff[1] & ~cs_prev_ff & (tgl_sync_ff[1] != tgl_seen_ff);
  assign aligned = (bit_cnt_ff == 3'h0);

  always_comb begin
    unique case (prot_ff)
      PROT_NONE: in_prot = 1'b0;
      PROT_EIGHTH: in_prot = (addr_ff >= PROT_EIGHTH_BASE);
      PROT_QUARTER: in_prot = (addr_ff >= PROT_QUARTER_BASE);
      PROT_HALF: in_prot = (addr_ff >= PROT_HALF_BASE);
      default: in_prot = 1'b1;
    endcase
  end

  assign do_write_enable_cmd = take & aligned & (opcode_ff == OP_WRITE_ENABLE) & (byte_cnt_ff == NB_ONE) & ~busy;
  assign do_write_disable_cmd = take & aligned & (opcode_ff == OP_WRITE_DISABLE) & (byte_cnt_ff == NB_ONE) & ~busy;
  assign do_wsr = take & aligned & (opcode_ff == OP_STATUS_WRITE) & wel_ff & ~busy &
                  (byte_cnt_ff == NB_STATUS_WRITE) & ~hw_locked;
  assign do_page = take & aligned & (opcode_ff == OP_PAGE_WRITE) & wel_ff & ~busy &
                   (byte_cnt_ff >= NB_PAGE_MIN) & ~in_prot;
  assign do_sect = take & aligned & (opcode_ff == OP_SECTOR_CLEAR) & wel_ff & ~busy &
                   (byte_cnt_ff == NB_SECTOR) & ~in_prot;
  assign do_full = take & aligned & (opcode_ff == OP_FULL_CLEAR) & wel_ff & ~busy &
                   (byte_cnt_ff == NB_ONE) & (prot_ff == PROT_NONE);

  always_comb begin
    nxt_sy = sy_ff;
    nxt_kind = kind_ff;
    nxt_cnt = cnt_ff;
    nxt_wel = wel_ff;
    nxt_prot = prot_ff;
    nxt_lock = lock_ff;
    nxt_pend = pend_ff;
    if (do_write_enable_cmd) begin
      nxt_wel = 1'b1;
    end
    if (do_write_disable_cmd) begin
      nxt_wel = 1'b0;
    end
    unique case (sy_ff)
      SY_IDLE: begin
        if (do_wsr || do_page || do_sect || do_full) begin
          nxt_sy = SY_CYC;
        end
        if (do_wsr) begin
          nxt_kind = KD_STATUS;
          nxt_cnt = 32'(STATUS_CYC);
          nxt_pend = wdata_ff;
        end else if (do_page) begin
          nxt_kind = KD_PAGE;
          nxt_cnt = 32'(PAGE_CYC);
        end else if (do_sect) begin
          nxt_kind = KD_SECTOR;
          nxt_cnt = 32'(SECTOR_CYC);
        end else if (do_full) begin
          nxt_kind = KD_FULL;
          nxt_cnt = 32'(FULL_CYC);
        end
      end
      SY_CYC: begin
        nxt_cnt = cnt_ff - CNT_ONE;
        if (cnt_ff == CNT_ONE) begin
          nxt_sy = SY_IDLE;
          nxt_wel = 1'b0;
          if ((kind_ff == KD_STATUS) && !hw_locked) begin
            // only lock and protect bits are writable
            nxt_lock = pend_ff[7];
            nxt_prot = pend_ff[4:2];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_sync_ff <= 2'b11;
      cs_prev_ff <= 1'b1;
      wp_sync_ff <= 2'b11;
      tgl_sync_ff <= 2'b00;
      tgl_seen_ff <= 1'b0;
      sy_ff <= SY_IDLE;
      kind_ff <= KD_STATUS;
      cnt_ff <= 32'h0000_0000;
      wel_ff <= 1'b0;
      prot_ff <= PROTECT_RESET;
      lock_ff <= LOCK_RESET;
      pend_ff <= 8'h00;
    end else if (ce_i) begin
      cs_sync_ff <= {cs_sync_ff[0], cs_n_i};
      cs_prev_ff <= cs_sync_ff[1];
      wp_sync_ff <= {wp_sync_ff[0], wp_n_i};
      tgl_sync_ff <= {tgl_sync_ff[0], frame_tgl_ff};
      tgl_seen_ff <= take ? tgl_sync_ff[1] : tgl_seen_ff;
      sy_ff <= nxt_sy;
      kind_ff <= nxt_kind;
      cnt_ff <= nxt_cnt;
      wel_ff <= nxt_wel;
      prot_ff <= nxt_prot;
      lock_ff <= nxt_lock;
      pend_ff <= nxt_pend;
    end
  end

  always_comb begin
    status_o.status_lock_bit = lock_ff;
    status_o.reserved = 2'b00;
    status_o.protect_size_hi = prot_ff[2];
    status_o.protect_size_mid = prot_ff[1];
    status_o.protect_size_lo = prot_ff[0];
    status_o.write_enable_latch = wel_ff;
    status_o.cycle_running_flag = busy;
  end
  assign hardware_locked_mode_o = hw_locked;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_wsr_take;
    take && (opcode_ff == OP_STATUS_WRITE) && ~busy;
  endsequence
  sequence s_wsr_refused;
    s_wsr_take ##0 (~wel_ff || hw_locked);
  endsequence

  chk_reserved_zero: assert property (status_o[6:5] == 2'b00)
    else $error("reserved status bits not zero");
  chk_busy_flag: assert property (status_o.cycle_running_flag ==
                                  (cnt_ff != 32'h0000_0000))
    else $error("busy flag does not match cycle state");
  chk_write_enable_cmd_sets: assert property (do_write_enable_cmd && ce_i |=> wel_ff)
    else $error("write enable did not set latch");
  chk_write_disable_cmd_clears: assert property (do_write_disable_cmd && ce_i |=> !wel_ff)
    else $error("write disable did not clear latch");
  chk_wsr_gate: assert property (s_wsr_refused |=> ce_i |-> sy_ff == SY_IDLE)
    else $error("status write ran while refused");
  chk_lock_hold: assert property (hw_locked && ce_i |=> $stable(lock_ff) && $stable(prot_ff))
    else $error("locked status bits changed");
  chk_cycle_end: assert property ((sy_ff == SY_CYC) && (cnt_ff == CNT_ONE) && ce_i
                                  |=> !wel_ff && !busy)
    else $error("cycle end did not clear latch and busy");
  chk_full_guard: assert property (take && (opcode_ff == OP_FULL_CLEAR) && !busy &&
                                   (prot_ff != PROT_NONE) |=> !busy)
    else $error("full clear started with protection");
  chk_stat_enter: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      (st == LK_OPC) && byte_done && (new_byte == OP_STATUS_READ) |=> state_ff == LK_STAT)
    else $error("status read not entered");
  chk_addr_wrap: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      (st == LK_RDATA) && byte_done && (addr_ff == ADDR_TOP) |=> addr_ff == ADDR_ZERO)
    else $error("read address did not wrap");
  chk_read_reject: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      (st == LK_OPC) && byte_done && (new_byte == OP_READ) && busy_link
      |=> state_ff == LK_IGN)
    else $error("read accepted during cycle");

endmodule
`default_nettype wire

// ---- sim/sfl_host_model.sv ----
/*
  Host controller model for the serial flash command block.
  Assumes the bench calls xfer one frame at a time; clock idles low.
*/
`default_nettype none
module sfl_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic serial_in_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] rd;
  logic oe_seen;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    serial_in_o = 1'b0;
    rd = '0;
    oe_seen = 1'b0;
  end
  // ************************************************************
  // one frame: nb bits out, then nr bits in
  // ************************************************************
  task automatic xfer(input int nb, input logic [63:0] wb, input int nr);
    int i;
    rd = '0;
    oe_seen = 1'b0;
    #7 cs_n_o = 1'b0;
    for (i = 0; i < nb + nr; i++) begin
      if (i < nb) serial_in_o = wb[nb-1-i];
      else serial_in_o = ~serial_in_o;
      #32;
      // sampled before the rise, device changes on the fall
      // an undriven output reads as the inverse, so a missing enable shows up
      if (i >= nb) rd = {rd[62:0], sdo_oe_i ? sdo_i : ~sdo_i};
      oe_seen = oe_seen | sdo_oe_i;
      sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    #100;
  endtask
endmodule
`default_nettype wire

// ---- sim/sfl_flash_cmd_tb.sv ----
/*
  Self-checking bench for the serial flash command block.
  Assumes the host model drives the link; array data is an address hash.
*/
`default_nettype none
module sfl_flash_cmd_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sfl_pkg::*;
  localparam int unsigned T_CYC = 8000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n = 1'b1;
  logic sclk, cs_n, si, sdo, sdo_oe, hlm;
  logic [23:0] mem_addr;
  logic [7:0] mem_data;
  sfl_status_t status;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  assign mem_data = mem_addr[7:0] ^ mem_addr[18:11];
  sfl_flash_cmd #(.STATUS_TIME_NS(T_CYC), .PAGE_TIME_NS(T_CYC), .SECTOR_TIME_NS(T_CYC),
    .FULL_TIME_NS(T_CYC)) sfl_flash_cmd_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(si), .wp_n_i(wp_n), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .mem_addr_o(mem_addr), .mem_data_i(mem_data), .status_o(status),
    .hardware_locked_mode_o(hlm));
  sfl_host_model sfl_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .serial_in_o(si),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] exp_mem(input logic [23:0] a);
    return a[7:0] ^ a[18:11];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input int nb, input logic [63:0] wb, input int nr);
    sfl_host_model_i.xfer(nb, wb, nr);
  endtask
  task automatic rd_link(input logic [7:0] e);
    xf(8, OP_STATUS_READ, 16);
    chk(sfl_host_model_i.rd[15:8], e);
    chk(sfl_host_model_i.rd[7:0], e);
    chk(sfl_host_model_i.rd[15:8] & 8'h9F, e & 8'h9F);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000 && status.cycle_running_flag !== 1'b0; i++) @(posedge clk_i);
    chk_flag(status.cycle_running_flag, 1'b0);
  endtask
  task automatic set_wp(input logic v);
    @(posedge clk_i);
    #1 wp_n = v;
    repeat (4) @(posedge clk_i);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_latch();
    chk(status, 8'h00);
    xf(9, {OP_WRITE_ENABLE, 1'b0}, 0);
    chk(status, 8'h00);
    xf(8, OP_WRITE_ENABLE, 0);
    chk(status, 8'h02);
    rd_link(8'h02);
    xf(8, OP_WRITE_DISABLE, 0);
    chk(status, 8'h00);
  endtask
  task automatic t_status_write();
    xf(16, {OP_STATUS_WRITE, 8'hFF}, 0);
    chk(status, 8'h00);
    xf(8, OP_WRITE_ENABLE, 0);
    xf(17, {OP_STATUS_WRITE, 8'hFF, 1'b1}, 0);
    chk(status, 8'h02);
    xf(16, {OP_STATUS_WRITE, 8'hFF}, 0);
    chk(status, 8'h03);
    rd_link(8'h03);
    xf(32, {OP_READ, 24'h00_0000}, 8);
    chk_flag(sfl_host_model_i.oe_seen, 1'b0);
    wait_idle();
    chk(status, 8'h9C);
  endtask
  task automatic t_protect();
    xf(8, OP_WRITE_ENABLE, 0);
    xf(8, OP_FULL_CLEAR, 0);
    chk(status, 8'h9E);
    set_wp(1'b0);
    chk_flag(hlm, 1'b1);
    xf(16, {OP_STATUS_WRITE, 8'h00}, 0);
    chk(status, 8'h9E);
    set_wp(1'b1);
    chk_flag(hlm, 1'b0);
    xf(40, {OP_PAGE_WRITE, 24'h00_0000, 8'h00}, 0);
    chk(status, 8'h9E);
    xf(32, {OP_SECTOR_CLEAR, 24'h00_0000}, 0);
    chk(status, 8'h9E);
    xf(16, {OP_STATUS_WRITE, 8'h00}, 0);
    wait_idle();
    chk(status, 8'h00);
    xf(8, OP_WRITE_ENABLE, 0);
    xf(8, OP_FULL_CLEAR, 0);
    chk(status, 8'h03);
    wait_idle();
    chk(status, 8'h00);
  endtask
  task automatic t_program();
    xf(40, {OP_PAGE_WRITE, 24'h07_0000, 8'hA5}, 0);
    chk(status, 8'h00);
    xf(8, OP_WRITE_ENABLE, 0);
    xf(40, {OP_PAGE_WRITE, 24'h07_0000, 8'hA5}, 0);
    chk(status, 8'h03);
    wait_idle();
    chk(status, 8'h00);
    xf(8, OP_WRITE_ENABLE, 0);
    xf(32, {OP_SECTOR_CLEAR, 24'h03_0000}, 0);
    chk(status, 8'h03);
    wait_idle();
    chk(status, 8'h00);
  endtask
  task automatic t_reads();
    xf(32, {OP_READ, 24'h07_FFFE}, 24);
    chk(sfl_host_model_i.rd[23:16], exp_mem(24'h07_FFFE));
    chk(sfl_host_model_i.rd[15:8], exp_mem(24'h07_FFFF));
    chk(sfl_host_model_i.rd[7:0], exp_mem(24'h00_0000));
    chk_flag(sdo_oe, 1'b0);
    xf(40, {OP_FAST_READ, 24'h01_2345, 8'h00}, 16);
    chk(sfl_host_model_i.rd[15:8], exp_mem(24'h01_2345));
    chk(sfl_host_model_i.rd[7:0], exp_mem(24'h01_2346));
  endtask
  task automatic t_ids();
    xf(32, {OP_WAKE_AND_ID, 24'h00_0000}, 16);
    chk(sfl_host_model_i.rd[15:8], PART_CODE);
    chk(sfl_host_model_i.rd[7:0], PART_CODE);
    xf(32, {OP_MAKER_PART_ID, 24'h00_0000}, 16);
    chk(sfl_host_model_i.rd[15:8], MAKER_CODE);
    chk(sfl_host_model_i.rd[7:0], PART_CODE);
    xf(32, {OP_MAKER_PART_ID, 24'h00_0001}, 16);
    chk(sfl_host_model_i.rd[15:8], PART_CODE);
    chk(sfl_host_model_i.rd[7:0], MAKER_CODE);
  endtask
  // ************************************************************
  // verdict, timeout, main sequence
  // ************************************************************
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 50000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    t_latch();
    t_status_write();
    t_protect();
    t_program();
    t_reads();
    t_ids();
    print_verdict();
  end
endmodule
`default_nettype wire
